// [hdl/mhi_consts.vh]
// mhi_consts.vh: register offsets, field positions, reset values and clock rates
// assumes: included by bare name from the motion halt and input design files
`ifndef MHI_CONSTS_VH
`define MHI_CONSTS_VH

`define MHI_NUM_AXES 8
`define MHI_CNT_W 32
`define MHI_CLK_HZ 10000000
`define MHI_ENC_MAX_HZ 15000000

// register byte offsets
`define MHI_REG_CTRL 12'h000
`define MHI_REG_STATUS 12'h004
`define MHI_REG_IRQ_STAT 12'h008
`define MHI_REG_IRQ_EN 12'h00c
`define MHI_REG_IRQ_CLR 12'h010
`define MHI_REG_INPUTS 12'h014
`define MHI_REG_IN_SEL 12'h018
`define MHI_REG_OFF_ON_ERR 12'h01c
`define MHI_REG_ENC_MODE 12'h020
`define MHI_REG_ENC_BASE 12'h040

// control register fields
`define MHI_CTRL_KEEP_PROG 0
`define MHI_CTRL_HALT_CLR 1
`define MHI_CTRL_RESET 32'h0000_0000

// status register fields
`define MHI_ST_HALTED 0
`define MHI_ST_HALT_LVL 1
`define MHI_ST_LOCKOUT 2
`define MHI_ST_SEL_IN 3
`define MHI_ST_RST_LVL 4

// interrupt status bits
`define MHI_IRQ_HALT 0
`define MHI_IRQ_LIMIT 1
`define MHI_IRQ_RESET 2
`define MHI_IRQ_LOCKOUT 3
`define MHI_IRQ_W 4

`define MHI_ENC_QUAD 1'b0
`define MHI_ENC_STEP 1'b1

`endif

// [hdl/mhi_sync2.v]
// mhi_sync2.v: two flip-flop synchroniser for a bus of pin levels
// assumes: inputs are asynchronous to pclk; only the second stage is read outside
`timescale 1ns/100ps
`default_nettype none
module mhi_sync2 #(
	parameter W = 1
) (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire [W-1:0] din, // raw pin levels
	output wire [W-1:0] dout // synchronised levels
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= din;
			sync_r <= meta_r;
		end
	end

	assign dout = sync_r;
endmodule
`default_nettype wire

// [hdl/mhi_enc_dec.v]
// mhi_enc_dec.v: one main encoder channel, quadrature or step and direction
// assumes: phase inputs already synchronised to pclk; one step per edge at most
`timescale 1ns/100ps
`default_nettype none
`include "mhi_consts.vh"
module mhi_enc_dec (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire phase_first, // synchronised channel a
	input wire phase_second, // synchronised channel b
	input wire step_mode, // 1 selects step and direction decoding
	input wire cnt_clr, // clear count to zero
	output reg [`MHI_CNT_W-1:0] count_r // signed position count
);
	reg a_d_r;
	reg b_d_r;
	reg up;
	reg dn;
	wire a_edge;
	wire b_edge;

	assign a_edge = phase_first ^ a_d_r;
	assign b_edge = phase_second ^ b_d_r;

	always @* begin
		up = 1'b0;
		dn = 1'b0;
		if (step_mode) begin
			// rising edge of a steps, b sets direction
			if (a_edge && phase_first) begin
				up = !phase_second;
				dn = phase_second;
			end
		end else if (a_edge != b_edge) begin
			// a leading b counts up; both edges at once is an illegal state, ignored
			up = (phase_first ^ phase_second) ? a_edge : b_edge;
			dn = !up;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_d_r <= 1'b0;
			b_d_r <= 1'b0;
			count_r <= {`MHI_CNT_W{1'b0}};
		end else begin
			a_d_r <= phase_first;
			b_d_r <= phase_second;
			if (cnt_clr)
				count_r <= {`MHI_CNT_W{1'b0}};
			else if (up)
				count_r <= count_r + {{(`MHI_CNT_W-1){1'b0}}, 1'b1};
			else if (dn)
				count_r <= count_r - {{(`MHI_CNT_W-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

// [hdl/mhi_top.v]
// mhi_top.v: halt, lockout, reset and general input logic with encoder decoders
// assumes: APB3 master on pclk; all pin inputs asynchronous to pclk
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "mhi_consts.vh"
// Operation
// - halt input edge stops controller at once
// - halt drops motion commands, no deceleration
// - limit switch gives decelerated stop instead
// - off-on-error axes: motor off on halt
// - other axes: fastest stop, stay servoing
// - halt kills programs unless configured otherwise
// - reset line resets, never master reset
// - lockout input shuts amplifier in hardware
// - general inputs 1-8 readable by index
// - wide variant adds inputs 9-16 same way
// - one halt, reset, lockout for all axes
// - encoders default quadrature, per-axis step option
// - step mode: a is pulse, b direction
// - quadrature counts correctly up to 15 MHz; here decoded on the 10 MHz pclk, at most one count per clock
module mhi_top (
	input wire pclk, // system clock, 10 MHz
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output wire pready, // apb ready, always one
	output reg [31:0] prdata, // apb read data
	output wire pslverr, // apb error on unmapped address
	input wire motion_halt_input, // shared halt pin, level
	input wire amp_lockout_input, // shared amplifier lockout pin
	input wire hw_reset_input, // shared reset line or button, active high
	input wire [7:0] general_inputs_low, // general inputs 1-8
	input wire [7:0] general_inputs_high, // general inputs 9-16
	input wire [`MHI_NUM_AXES-1:0] limit_active, // any limit switch per axis, pin
	input wire [`MHI_NUM_AXES-1:0] enc_phase_first, // encoder channel a per axis
	input wire [`MHI_NUM_AXES-1:0] enc_phase_second, // encoder channel b per axis
	output reg motion_cmd_stop, // stop motion commands now, no profile
	output reg [`MHI_NUM_AXES-1:0] axis_motor_off, // axis out of servo control
	output reg [`MHI_NUM_AXES-1:0] axis_fast_stop, // axis stops fast, stays servo
	output reg [`MHI_NUM_AXES-1:0] axis_decel_stop, // axis decelerated stop request
	output reg program_abort, // one-cycle pulse: terminate programs
	output reg ctrl_soft_reset, // one-cycle pulse: controller reset
	output reg amp_shutdown, // amplifier hardware shutdown level
	output wire irq // interrupt, level, active high
);
	wire halt_s;
	wire lock_s;
	wire rst_s;
	wire [15:0] gin_s;
	wire [`MHI_NUM_AXES-1:0] lim_s;
	wire [`MHI_NUM_AXES-1:0] pa_s;
	wire [`MHI_NUM_AXES-1:0] pb_s;
	reg halt_d_r;
	reg rst_d_r;
	reg lim_d_r;
	reg lock_d_r;
	reg halted_r;
	reg keep_prog_r;
	reg [4:0] in_sel_r;
	wire [4:0] sel_idx;
	reg [`MHI_NUM_AXES-1:0] off_on_err_r;
	reg [`MHI_NUM_AXES-1:0] enc_mode_r;
	reg [`MHI_NUM_AXES-1:0] enc_clr_r;
	reg [`MHI_IRQ_W-1:0] irq_stat_r;
	reg [`MHI_IRQ_W-1:0] irq_en_r;
	reg [`MHI_IRQ_W-1:0] irq_set;
	reg [`MHI_IRQ_W-1:0] irq_clr;
	wire [`MHI_CNT_W-1:0] enc_count [0:`MHI_NUM_AXES-1];
	wire halt_edge;
	wire wr_en;
	wire rd_en;
	wire addr_ok;
	wire sel_bit;
	wire enc_hit;
	wire [2:0] enc_idx;
	reg [31:0] rd_mux;

	// one synchroniser bank for every pin, shared pins once only
	mhi_sync2 #(.W(3 + 16 + 3 * `MHI_NUM_AXES)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({motion_halt_input, amp_lockout_input, hw_reset_input,
			general_inputs_high, general_inputs_low,
			limit_active, enc_phase_first, enc_phase_second}),
		.dout({halt_s, lock_s, rst_s, gin_s, lim_s, pa_s, pb_s})
	);

	// encoder decoders; pclk must sample faster than encoder edges
	genvar gi;
	generate
		for (gi = 0; gi < `MHI_NUM_AXES; gi = gi + 1) begin : g_enc
			mhi_enc_dec u_dec (
				.pclk(pclk),
				.presetn(presetn),
				.phase_first(pa_s[gi]),
				.phase_second(pb_s[gi]),
				.step_mode(enc_mode_r[gi]),
				.cnt_clr(enc_clr_r[gi]),
				.count_r(enc_count[gi])
			);
		end
	endgenerate

	// apb decode, zero wait states
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	// read data is loaded in the setup cycle so it already stands at the access edge
	assign rd_en = psel & ~penable & ~pwrite;
	assign enc_hit = (paddr[11:5] == `MHI_REG_ENC_BASE >> 5) && (paddr[1:0] == 2'b00);
	assign enc_idx = paddr[4:2];
	assign addr_ok = enc_hit ||
		paddr == `MHI_REG_CTRL || paddr == `MHI_REG_STATUS ||
		paddr == `MHI_REG_IRQ_STAT || paddr == `MHI_REG_IRQ_EN ||
		paddr == `MHI_REG_IRQ_CLR || paddr == `MHI_REG_INPUTS ||
		paddr == `MHI_REG_IN_SEL || paddr == `MHI_REG_OFF_ON_ERR ||
		paddr == `MHI_REG_ENC_MODE;
	assign pslverr = psel & penable & ~addr_ok;

	// index 1..16, zero or out of range reads as zero
	// five bits so that index 16 can be written at all
	assign sel_idx = in_sel_r - 5'h01;
	assign sel_bit = (in_sel_r == 5'h00 || in_sel_r > 5'h10) ? 1'b0 :
		gin_s[sel_idx[3:0]];

	// any halt level change, either direction, is an event
	assign halt_edge = halt_s ^ halt_d_r;

	always @* begin
		irq_set = {`MHI_IRQ_W{1'b0}};
		irq_set[`MHI_IRQ_HALT] = halt_edge;
		irq_set[`MHI_IRQ_LIMIT] = (|lim_s) & ~lim_d_r;
		irq_set[`MHI_IRQ_RESET] = rst_s & ~rst_d_r;
		irq_set[`MHI_IRQ_LOCKOUT] = lock_s & ~lock_d_r;
		irq_clr = (wr_en && paddr == `MHI_REG_IRQ_CLR) ? pwdata[`MHI_IRQ_W-1:0] :
			{`MHI_IRQ_W{1'b0}};
	end

	assign irq = |(irq_stat_r & irq_en_r);

	always @* begin
		rd_mux = 32'h0000_0000;
		if (enc_hit)
			rd_mux = enc_count[enc_idx];
		else
			case (paddr)
			`MHI_REG_CTRL: rd_mux[`MHI_CTRL_KEEP_PROG] = keep_prog_r;
			`MHI_REG_STATUS: begin
				rd_mux[`MHI_ST_HALTED] = halted_r;
				rd_mux[`MHI_ST_HALT_LVL] = halt_s;
				rd_mux[`MHI_ST_LOCKOUT] = lock_s;
				rd_mux[`MHI_ST_SEL_IN] = sel_bit;
				rd_mux[`MHI_ST_RST_LVL] = rst_s;
			end
			`MHI_REG_IRQ_STAT: rd_mux[`MHI_IRQ_W-1:0] = irq_stat_r;
			`MHI_REG_IRQ_EN: rd_mux[`MHI_IRQ_W-1:0] = irq_en_r;
			`MHI_REG_INPUTS: rd_mux[15:0] = gin_s;
			`MHI_REG_IN_SEL: rd_mux[4:0] = in_sel_r;
			`MHI_REG_OFF_ON_ERR: rd_mux[`MHI_NUM_AXES-1:0] = off_on_err_r;
			`MHI_REG_ENC_MODE: rd_mux[`MHI_NUM_AXES-1:0] = enc_mode_r;
			default: rd_mux = 32'h0000_0000;
			endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_d_r <= 1'b0;
			rst_d_r <= 1'b0;
			lim_d_r <= 1'b0;
			lock_d_r <= 1'b0;
			halted_r <= 1'b0;
			keep_prog_r <= 1'b0;
			in_sel_r <= 5'h00;
			off_on_err_r <= {`MHI_NUM_AXES{1'b0}};
			enc_mode_r <= {`MHI_NUM_AXES{`MHI_ENC_QUAD}};
			enc_clr_r <= {`MHI_NUM_AXES{1'b0}};
			irq_stat_r <= {`MHI_IRQ_W{1'b0}};
			irq_en_r <= {`MHI_IRQ_W{1'b0}};
			prdata <= 32'h0000_0000;
			motion_cmd_stop <= 1'b0;
			axis_motor_off <= {`MHI_NUM_AXES{1'b0}};
			axis_fast_stop <= {`MHI_NUM_AXES{1'b0}};
			axis_decel_stop <= {`MHI_NUM_AXES{1'b0}};
			program_abort <= 1'b0;
			ctrl_soft_reset <= 1'b0;
			amp_shutdown <= 1'b0;
		end else begin
			halt_d_r <= halt_s;
			rst_d_r <= rst_s;
			lim_d_r <= |lim_s;
			lock_d_r <= lock_s;
			enc_clr_r <= {`MHI_NUM_AXES{1'b0}};
			// set wins over a clear in the same cycle
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
			if (rd_en)
				prdata <= rd_mux;
			if (wr_en) begin
				case (paddr)
				`MHI_REG_CTRL: keep_prog_r <= pwdata[`MHI_CTRL_KEEP_PROG];
				`MHI_REG_IRQ_EN: irq_en_r <= pwdata[`MHI_IRQ_W-1:0];
				`MHI_REG_IN_SEL: in_sel_r <= pwdata[4:0];
				`MHI_REG_OFF_ON_ERR: off_on_err_r <= pwdata[`MHI_NUM_AXES-1:0];
				`MHI_REG_ENC_MODE: enc_mode_r <= pwdata[`MHI_NUM_AXES-1:0];
				default: begin
					if (enc_hit)
						enc_clr_r[enc_idx] <= 1'b1;
				end
				endcase
			end
			// halt latches until software releases it; a new edge wins
			if (halt_edge)
				halted_r <= 1'b1;
			else if (wr_en && paddr == `MHI_REG_CTRL && pwdata[`MHI_CTRL_HALT_CLR])
				halted_r <= 1'b0;
			// combinational decisions are registered so they act the edge after detection
			motion_cmd_stop <= halt_edge | halted_r;
			axis_motor_off <= {`MHI_NUM_AXES{halt_edge | halted_r}} & off_on_err_r;
			axis_fast_stop <= {`MHI_NUM_AXES{halt_edge | halted_r}} & ~off_on_err_r;
			// limits use the profiled stop, never the halt path
			axis_decel_stop <= lim_s & ~{`MHI_NUM_AXES{halt_edge | halted_r}};
			program_abort <= halt_edge & ~keep_prog_r;
			// controller reset only; configuration registers are kept, no master reset
			ctrl_soft_reset <= rst_s & ~rst_d_r;
			amp_shutdown <= lock_s;
		end
	end
endmodule
`default_nettype wire

// [testbench/mhi_top_monitor.sv]
// mhi_top_monitor.sv: port checks for the halt and input block
// assumes: bound into mhi_top; one pclk domain
`timescale 1ns/100ps
`default_nettype none
module mhi_top_monitor (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // write
	input wire logic pslverr, // error
	input wire logic motion_halt_input, // halt pin
	input wire logic amp_lockout_input, // lockout pin
	input wire logic hw_reset_input, // reset pin
	input wire logic [7:0] limit_active, // limits
	input wire logic motion_cmd_stop, // halted
	input wire logic [7:0] axis_motor_off, // off
	input wire logic [7:0] axis_fast_stop, // fast
	input wire logic [7:0] axis_decel_stop, // decel
	input wire logic program_abort, // kill
	input wire logic ctrl_soft_reset, // reset pulse
	input wire logic amp_shutdown // amp off
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// two sync flops and edge detect, one spare edge
	property p_halt; $changed(motion_halt_input) |-> ##[1:4] motion_cmd_stop; endproperty
	a_halt: assert property (p_halt) else $error("halt late");
	// a clearing write shows at the output one edge late, so two write cycles are excused
	property p_hold; motion_cmd_stop && !(psel && penable && pwrite) &&
		!$past(psel && penable && pwrite) |=> motion_cmd_stop; endproperty
	a_hold: assert property (p_hold) else $error("halt lost");
	property p_split; (axis_motor_off | axis_fast_stop) == {8{motion_cmd_stop}} &&
		(axis_motor_off & axis_fast_stop) == 8'h00; endproperty
	a_split: assert property (p_split) else $error("axis split");
	property p_abort; program_abort |-> motion_cmd_stop ##1 !program_abort; endproperty
	a_abort: assert property (p_abort) else $error("abort pulse");
	property p_rst; $rose(hw_reset_input) |-> ##[1:4] $rose(ctrl_soft_reset) ##1 !ctrl_soft_reset; endproperty
	a_rst: assert property (p_rst) else $error("reset pulse");
	property p_lock; $stable(amp_lockout_input) [*4] |-> amp_shutdown == amp_lockout_input; endproperty
	a_lock: assert property (p_lock) else $error("lockout");
	property p_decel; (!motion_cmd_stop && $stable(limit_active)) [*5] |-> axis_decel_stop == limit_active; endproperty
	a_decel: assert property (p_decel) else $error("decel");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("slverr");
endmodule
bind mhi_top mhi_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pslverr(pslverr), .limit_active(limit_active),
	.motion_halt_input(motion_halt_input), .amp_lockout_input(amp_lockout_input),
	.hw_reset_input(hw_reset_input), .motion_cmd_stop(motion_cmd_stop),
	.axis_motor_off(axis_motor_off), .axis_fast_stop(axis_fast_stop),
	.axis_decel_stop(axis_decel_stop), .program_abort(program_abort),
	.ctrl_soft_reset(ctrl_soft_reset), .amp_shutdown(amp_shutdown));
`default_nettype wire

// [testbench/mhi_enc_model.sv]
// mhi_enc_model.sv: encoder pins of all axes, driven by task calls
// assumes: each level held at least three edges, slower than the synchroniser
`timescale 1ns/100ps
`default_nettype none
module mhi_enc_model (
	input wire logic pclk, // clock
	output logic [7:0] enc_a, // channel a
	output logic [7:0] enc_b // channel b
);
	initial begin
		enc_a = 8'h00;
		enc_b = 8'h00;
	end
	// a leads b counting up: 00 10 11 01
	task quad(input int ax, input bit up);
		@(posedge pclk);
		if ((enc_a[ax] == enc_b[ax]) == up) enc_a[ax] <= ~enc_a[ax];
		else enc_b[ax] <= ~enc_b[ax];
		repeat (3) @(posedge pclk);
	endtask
	// direction settles before the step rises
	task pulse(input int ax, input bit up);
		@(posedge pclk);
		enc_b[ax] <= ~up;
		repeat (3) @(posedge pclk);
		enc_a[ax] <= 1'b1;
		repeat (3) @(posedge pclk);
		enc_a[ax] <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// [testbench/mhi_top_tb.sv]
// mhi_top_tb.sv: self-checking bench for the halt and input block
// assumes: encoder model on the phase pins; bench drives apb and switches
`timescale 1ns/100ps
`default_nettype none
`include "mhi_consts.vh"
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin bad_count++; \
$display("[ERR] %0t %h %h", $time, g, x); end end
module mhi_top_tb;
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic e;} mhi_row_t;
	// a read expects d, a write sends it
	mhi_row_t rows [8] = '{'{0, 12'h000, 0, 0}, '{0, 12'h020, 0, 0}, '{1, 12'h008, 15, 0},
		'{0, 12'h008, 0, 0}, '{1, 12'hffc, 1, 1}, '{0, 12'hffc, 0, 1}, '{1, 12'h01c, 15, 0},
		'{0, 12'h01c, 15, 0}};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic halt = 1'b0, lock = 1'b0, rst_in = 1'b0, pready, pslverr, err, stop, abort, s_rst, amp, irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] gin = 16'hc35a;
	logic [7:0] limit = 8'h00, enc_a, enc_b, m_off, f_stop, decel;
	int bad_count = 0, n_tests = 0, cyc = 0, n_ab, n_rs, i;
	mhi_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .motion_halt_input(halt), .amp_lockout_input(lock),
		.hw_reset_input(rst_in), .general_inputs_low(gin[7:0]), .general_inputs_high(gin[15:8]),
		.limit_active(limit), .enc_phase_first(enc_a), .enc_phase_second(enc_b),
		.motion_cmd_stop(stop), .axis_motor_off(m_off), .axis_fast_stop(f_stop),
		.axis_decel_stop(decel), .program_abort(abort), .ctrl_soft_reset(s_rst),
		.amp_shutdown(amp), .irq(irq));
	mhi_enc_model em (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b));
	always #50 pclk = ~pclk;
	always @(posedge pclk) if (++cyc == 4000) begin
		bad_count++;
		conclude();
	end
	task automatic conclude();
		if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// prdata is loaded in setup, so it stands at the access edge and is taken there
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// let the access edge settle before callers look at outputs
		#1;
	endtask
	task automatic watch(input int n);
		n_ab = 0;
		n_rs = 0;
		repeat (n) begin
			@(posedge pclk);
			#1 n_ab += abort;
			n_rs += s_rst;
		end
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1 `CHK({stop, m_off, f_stop, decel, abort, s_rst, amp, irq}, 29'h0)
		foreach (rows[k]) begin
			apb(rows[k].w, rows[k].a, rows[k].d);
			if (!rows[k].w) `CHK(rd, rows[k].d)
			`CHK(err, rows[k].e)
		end
		for (i = 0; i < 17; i++) begin
			apb(1'b1, `MHI_REG_IN_SEL, 32'(i));
			apb(1'b0, `MHI_REG_STATUS, 32'h0);
			`CHK(rd[`MHI_ST_SEL_IN], i ? gin[i-1] : 1'b0)
		end
		apb(1'b1, `MHI_REG_IRQ_EN, 32'h9);
		@(posedge pclk);
		limit <= 8'h21;
		watch(5);
		`CHK(decel, 8'h21)
		@(posedge pclk);
		halt <= 1'b1;
		watch(6);
		`CHK(n_ab, 1)
		`CHK({stop, irq, decel}, 10'h300)
		`CHK({m_off, f_stop}, 16'h0ff0)
		apb(1'b1, `MHI_REG_CTRL, 32'h2);
		apb(1'b1, `MHI_REG_IRQ_CLR, 32'h3);
		`CHK({stop, irq}, 2'b00)
		apb(1'b1, `MHI_REG_CTRL, 32'h1);
		@(posedge pclk);
		halt <= 1'b0;
		limit <= 8'h00;
		watch(6);
		`CHK(n_ab, 0)
		`CHK(stop, 1'b1)
		apb(1'b1, `MHI_REG_CTRL, 32'h2);
		@(posedge pclk);
		rst_in <= 1'b1;
		watch(6);
		`CHK(n_rs, 1)
		apb(1'b0, `MHI_REG_OFF_ON_ERR, 32'h0);
		`CHK(rd, 32'hf)
		@(posedge pclk);
		lock <= 1'b1;
		rst_in <= 1'b0;
		watch(5);
		`CHK({amp, irq}, 2'b11)
		apb(1'b1, `MHI_REG_IRQ_EN, 32'h2);
		`CHK(irq, 1'b0)
		apb(1'b1, `MHI_REG_IRQ_EN, 32'h9);
		`CHK(irq, 1'b1)
		apb(1'b1, `MHI_REG_IRQ_CLR, 32'h9);
		`CHK({irq, amp}, 2'b01)
		apb(1'b0, `MHI_REG_IRQ_STAT, 32'h0);
		`CHK(rd, 32'h4)
		apb(1'b0, `MHI_REG_STATUS, 32'h0);
		`CHK(rd, 32'hc)
		for (i = 0; i < 13; i++) em.quad(0, i < 10);
		apb(1'b1, `MHI_REG_ENC_MODE, 32'h20);
		for (i = 0; i < 4; i++) em.pulse(5, i < 1);
		apb(1'b0, `MHI_REG_ENC_BASE, 32'h0);
		`CHK(rd, 32'h7)
		apb(1'b0, `MHI_REG_ENC_BASE + 12'h014, 32'h0);
		`CHK(rd, 32'hfffffffe)
		conclude();
	end
endmodule
`default_nettype wire
